// [dout_channel.sv]
`timescale 1ns/1ps
// Purpose: Conditioning logic for one programmable digital output.
// Assumes: Settings are static software values on the processing clock.
// Notes: Drive status inputs are pins and are synchronised.
// ===========================================================
module dout_channel
  import dout_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // Drive status pins
  input wire logic MODULATING_IN,
  input wire logic ALARM_IN,
  // Analog variables
  input wire logic signed [VAR_W-1:0] ANALOG_A_IN,
  input wire logic signed [VAR_W-1:0] ANALOG_B_IN,
  // Settings
  input wire logic [3:0] OUTPUT_MODE_IN,
  input wire logic [SRC_W-1:0] VAR_A_SELECT_IN,
  input wire logic [SRC_W-1:0] VAR_B_SELECT_IN,
  input wire logic [SRC_W-1:0] VAR_C_SELECT_IN,
  input wire logic [2:0] TEST_A_OP_IN,
  input wire logic [2:0] TEST_B_OP_IN,
  input wire logic signed [VAR_W-1:0] THRESHOLD_A_IN,
  input wire logic signed [VAR_W-1:0] THRESHOLD_B_IN,
  input wire logic [3:0] AB_FUNCTION_IN,
  input wire logic [3:0] SECOND_FUNCTION_IN,
  input wire logic POLARITY_IN,
  input wire logic [PHASE_W-1:0] SAW_STEP_IN,
  // Output
  output logic OUTPUT_CHANNEL_OUT,
  output logic RUN_OK_OUT
);
  typedef struct packed {
    logic [1:0] run_sync;
    logic [1:0] alarm_sync;
    logic test_a;
    logic test_b;
    logic latch;
    logic out;
    logic run_ok;
  } chan_state_t;
  chan_state_t q, d;
  saw_if saw();
  out_mode_t mode;

  // ===========================================================
  // Helpers
  function automatic logic sel_bool(input logic [SRC_W-1:0] sel,
                                    input logic run_ok, input logic alarm,
                                    input logic signed [VAR_W-1:0] a,
                                    input logic signed [VAR_W-1:0] b);
    logic r;
    r = 1'b0;
    case (sel)
      SRC_RUN_OK: r = run_ok;
      SRC_ALARM: r = alarm;
      SRC_ANALOG_A: r = (a != '0);
      SRC_ANALOG_B: r = (b != '0);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic signed [VAR_W-1:0] sel_var(input logic [SRC_W-1:0] sel,
                                                      input logic signed [VAR_W-1:0] a,
                                                      input logic signed [VAR_W-1:0] b);
    return (sel == SRC_ANALOG_B) ? b : a;
  endfunction

  function automatic logic compare(input logic [2:0] op, input logic force_abs,
                                   input logic signed [VAR_W-1:0] x,
                                   input logic signed [VAR_W-1:0] t);
    logic signed [VAR_W:0] xv;
    logic signed [VAR_W:0] tv;
    logic r;
    xv = {x[VAR_W-1], x};
    tv = {t[VAR_W-1], t};
    if (op[OP_ABS_BIT] || force_abs) begin
      xv = (xv < 0) ? -xv : xv;
    end
    r = 1'b0;
    case (op[1:0])
      OP_GT: r = xv > tv;
      OP_GE: r = xv >= tv;
      OP_LT: r = xv < tv;
      OP_LE: r = xv <= tv;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic combine(input logic [3:0] fn, input logic a, input logic b,
                                   input logic a_prev, input logic b_prev,
                                   input logic hold);
    logic r;
    logic a_r;
    logic b_r;
    logic a_f;
    logic b_f;
    a_r = a && !a_prev;
    b_r = b && !b_prev;
    a_f = !a && a_prev;
    b_f = !b && b_prev;
    r = hold;
    case (fn)
      FN_OR: r = a | b;
      FN_AND: r = a & b;
      FN_XOR: r = a ^ b;
      FN_NOR: r = !(a | b);
      FN_NAND: r = !(a & b);
      FN_SET_RST_RISE: r = b_r ? 1'b0 : (a_r ? 1'b1 : hold);
      FN_RST_SET_RISE: r = a_r ? 1'b0 : (b_r ? 1'b1 : hold);
      FN_SET_RST_FALL: r = b_f ? 1'b0 : (a_f ? 1'b1 : hold);
      FN_RST_SET_FALL: r = a_f ? 1'b0 : (b_f ? 1'b1 : hold);
      default: r = hold;
    endcase
    return r;
  endfunction

  // ===========================================================
  // Sawtooth
  assign saw.peak = THRESHOLD_A_IN;
  assign saw.floor_v = THRESHOLD_B_IN;
  assign saw.step = SAW_STEP_IN;
  assign saw.enable = (OUTPUT_MODE_IN == MODE_PWM);

  saw_gen u_saw (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .s(saw.gen)
  );

  // ===========================================================
  // Processing chain
  logic run_s;
  logic alarm_s;
  logic signed [VAR_W-1:0] var_a;
  logic signed [VAR_W-1:0] var_b;
  logic abs_mode;
  logic ta;
  logic tb;
  logic fab;
  logic res;

  assign mode = out_mode_t'(OUTPUT_MODE_IN);

  always_comb begin
    d = q;
    d.run_sync = {q.run_sync[0], MODULATING_IN};
    d.alarm_sync = {q.alarm_sync[0], ALARM_IN};
    run_s = q.run_sync[1];
    alarm_s = q.alarm_sync[1];
    d.run_ok = run_s;
    var_a = sel_var(VAR_A_SELECT_IN, ANALOG_A_IN, ANALOG_B_IN);
    var_b = sel_var(VAR_B_SELECT_IN, ANALOG_A_IN, ANALOG_B_IN);
    abs_mode = (mode == MODE_ABSOLUTE_BRAKE_MODE) || (mode == MODE_ABS_LIFT);
    ta = compare(TEST_A_OP_IN, abs_mode, var_a, THRESHOLD_A_IN);
    tb = compare(TEST_B_OP_IN, abs_mode, var_b, THRESHOLD_B_IN);
    fab = 1'b0;
    res = 1'b0;
    unique case (mode)
      MODE_DISABLE: res = 1'b0;
      MODE_DIGITAL: begin
        res = sel_bool(VAR_A_SELECT_IN, run_s, alarm_s, ANALOG_A_IN, ANALOG_B_IN);
      end
      MODE_DBL_DIGITAL: begin
        ta = sel_bool(VAR_A_SELECT_IN, run_s, alarm_s, ANALOG_A_IN, ANALOG_B_IN);
        tb = sel_bool(VAR_B_SELECT_IN, run_s, alarm_s, ANALOG_A_IN, ANALOG_B_IN);
        fab = combine(AB_FUNCTION_IN, ta, tb, q.test_a, q.test_b, q.latch);
        res = fab;
      end
      MODE_PWM: begin
        res = compare(TEST_A_OP_IN, 1'b0, var_a, saw.value);
      end
      default: begin
        fab = combine(AB_FUNCTION_IN, ta, tb, q.test_a, q.test_b, q.latch);
        if ((mode == MODE_BRAKE || mode == MODE_ABSOLUTE_BRAKE_MODE) && alarm_s) begin
          fab = 1'b0;
        end
        res = fab;
      end
    endcase
    d.test_a = ta;
    d.test_b = tb;
    d.latch = (mode == MODE_DIGITAL || mode == MODE_PWM) ? q.latch : fab;
    if (VAR_C_SELECT_IN != SRC_DISABLED && mode != MODE_DIGITAL && mode != MODE_PWM) begin
      res = combine(SECOND_FUNCTION_IN, res,
                    sel_bool(VAR_C_SELECT_IN, run_s, alarm_s, ANALOG_A_IN, ANALOG_B_IN),
                    res, 1'b0, res);
    end
    d.out = (POLARITY_IN == POL_POSITIVE) ? res : !res;
    if (mode == MODE_DISABLE || OUTPUT_MODE_IN > MODE_PWM) begin
      d.out = 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign OUTPUT_CHANNEL_OUT = q.out;
  assign RUN_OK_OUT = q.run_ok;

  // ===========================================================
  // Checks
  disable_low_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    OUTPUT_MODE_IN == MODE_DISABLE |=> !OUTPUT_CHANNEL_OUT)
    else $error("Disabled output high");
  // The synchroniser restarts empty after reset, so the lag only holds three clean cycles later.
  runok_sync_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    $past(RESET_N_IN) && $past(RESET_N_IN, 2) && $past(RESET_N_IN, 3)
    |-> RUN_OK_OUT == $past(MODULATING_IN, 3)) else $error("Run ok lag wrong");
  brake_alarm_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (mode == MODE_ABSOLUTE_BRAKE_MODE && q.alarm_sync[1] && VAR_C_SELECT_IN == SRC_DISABLED
     && POLARITY_IN) |=> !OUTPUT_CHANNEL_OUT) else $error("Brake on under alarm");
  digital_follow_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (mode == MODE_DIGITAL && VAR_A_SELECT_IN == SRC_ALARM && !POLARITY_IN)
    |=> OUTPUT_CHANNEL_OUT == !$past(q.alarm_sync[1])) else $error("Fail-safe wrong");
  latch_set_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (mode == MODE_DBL_ANALOG && AB_FUNCTION_IN == FN_SET_RST_RISE && ta && !q.test_a
     && !(tb && !q.test_b)) |=> q.latch) else $error("Latch not set");
  cov_pwm_c: cover property (@(posedge MCLK_IN) mode == MODE_PWM && OUTPUT_CHANNEL_OUT);
  cov_latch_c: cover property (@(posedge MCLK_IN) $rose(q.latch));
  cov_brake_c: cover property (@(posedge MCLK_IN) mode == MODE_ABSOLUTE_BRAKE_MODE && $fell(q.out));
endmodule

// [dout_pkg.sv]
// Purpose: Shared constants and types for the programmable digital output.
// Assumes: Signed analog variables of VAR_W bits, one processing clock.
// Notes: Encodings of tests and functions follow the parameter ranges.
package dout_pkg;
  // ===========================================================
  // Widths
  localparam int VAR_W = 16;
  localparam int SRC_W = 3;
  // ===========================================================
  // Output modes
  typedef enum logic [3:0] {
    MODE_DISABLE = 4'h0,
    MODE_DIGITAL = 4'h1,
    MODE_DBL_DIGITAL = 4'h2,
    MODE_ANALOG = 4'h3,
    MODE_DBL_ANALOG = 4'h4,
    MODE_DBL_FULL = 4'h5,
    MODE_BRAKE = 4'h6,
    MODE_ABSOLUTE_BRAKE_MODE = 4'h7,
    MODE_ABS_LIFT = 4'h8,
    MODE_PWM = 4'h9
  } out_mode_t;
  // ===========================================================
  // Test operators, low two bits compare, bit 2 selects magnitude
  localparam logic [1:0] OP_GT = 2'h0;
  localparam logic [1:0] OP_GE = 2'h1;
  localparam logic [1:0] OP_LT = 2'h2;
  localparam logic [1:0] OP_LE = 2'h3;
  localparam int OP_ABS_BIT = 2;
  // ===========================================================
  // Combining functions of f(A,B) and of the second stage
  localparam logic [3:0] FN_OR = 4'h0;
  localparam logic [3:0] FN_SET_RST_RISE = 4'h1;
  localparam logic [3:0] FN_RST_SET_RISE = 4'h2;
  localparam logic [3:0] FN_SET_RST_FALL = 4'h3;
  localparam logic [3:0] FN_RST_SET_FALL = 4'h4;
  localparam logic [3:0] FN_AND = 4'h5;
  localparam logic [3:0] FN_XOR = 4'h6;
  localparam logic [3:0] FN_NOR = 4'h7;
  localparam logic [3:0] FN_NAND = 4'h8;
  // ===========================================================
  // Boolean source selection codes
  localparam logic [SRC_W-1:0] SRC_DISABLED = 3'h0;
  localparam logic [SRC_W-1:0] SRC_RUN_OK = 3'h1;
  localparam logic [SRC_W-1:0] SRC_ALARM = 3'h3;
  localparam logic [SRC_W-1:0] SRC_ANALOG_A = 3'h4;
  localparam logic [SRC_W-1:0] SRC_ANALOG_B = 3'h5;
  // ===========================================================
  // Sawtooth phase accumulator width, clock rate, reset and polarity values
  localparam int PHASE_W = 32;
  localparam real CLK_HZ = 20.0e6;
  localparam logic RESET_LATCH = 1'b0;
  localparam logic POL_POSITIVE = 1'b1;
endpackage

// [saw_if.sv]
`timescale 1ns/1ps
// Purpose: Carries sawtooth settings and the running value between modules.
// Assumes: One clock domain.
// Notes: The generator side drives value.
interface saw_if;
  import dout_pkg::*;
  logic signed [VAR_W-1:0] peak;
  logic signed [VAR_W-1:0] floor_v;
  logic [PHASE_W-1:0] step;
  logic enable;
  logic signed [VAR_W-1:0] value;
  modport gen(input peak, input floor_v, input step, input enable, output value);
  modport user(output peak, output floor_v, output step, output enable, input value);
endinterface

// [saw_gen.sv]
`timescale 1ns/1ps
// Purpose: Sawtooth from floor to peak at a programmed repetition rate.
// Assumes: step is the phase increment per clock, 2^32 * f / f_clk.
// Notes: Value is floor plus the scaled phase, so the span is exact at wrap.
module saw_gen
  import dout_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  saw_if.gen s
);
  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic signed [VAR_W-1:0] value;
  } saw_state_t;
  saw_state_t q, d;
  logic signed [VAR_W+1:0] span;
  logic signed [VAR_W+PHASE_W+2:0] prod;

  always_comb begin
    d = q;
    span = {{2{s.peak[VAR_W-1]}}, s.peak} - {{2{s.floor_v[VAR_W-1]}}, s.floor_v};
    prod = span * $signed({1'b0, q.phase});
    if (s.enable) begin
      d.phase = q.phase + s.step;
    end else begin
      d.phase = '0;
    end
    d.value = s.floor_v + VAR_W'(prod >>> PHASE_W);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s.value = q.value;

  saw_floor_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !s.enable |=> q.phase == '0) else $error("Saw phase not cleared");
endmodule

// [relay_model.sv]
`timescale 1ns/1ps
// Purpose: Relay contact on the far side of the digital output.
// Assumes: The coil is sampled on the processing clock.
// Notes: Counts closed cycles and closures so duty and period can be judged.
module relay_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Coil and count clear
  input wire logic coil_in,
  input wire logic clear_in,
  // Contact and counts
  output logic closed_out,
  output logic [31:0] on_cycles_out,
  output logic [31:0] closures_out
);
  // ===========================================================
  // Contact
  // Bounce is left out, so a closure is counted once per coil pulse.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      closed_out <= 1'b0;
      on_cycles_out <= 32'h0;
      closures_out <= 32'h0;
    end else begin
      closed_out <= coil_in;
      if (clear_in) begin
        on_cycles_out <= 32'h0;
        closures_out <= 32'h0;
      end else begin
        on_cycles_out <= on_cycles_out + {31'h0, coil_in};
        closures_out <= closures_out + {31'h0, coil_in & ~closed_out};
      end
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
// Purpose: Self-checking bench for the programmable digital output.
// Assumes: 20 MHz clock, inputs driven 2 ns after each rising edge.
// Notes: Five settle cycles cover the three cycle pin latency.
module tb;
  import dout_pkg::*;
  // ===========================================================
  // Signals
  logic clk, rst_n, mod_pin, alarm_pin, pol, clr, dout, run_ok, closed;
  logic signed [VAR_W-1:0] ana_a, ana_b, thr_a, thr_b;
  logic [3:0] mode, fn_ab, fn_2;
  logic [SRC_W-1:0] sel_a, sel_b, sel_c;
  logic [2:0] op_a, op_b;
  logic [PHASE_W-1:0] step;
  logic [31:0] on_cyc, closures;
  int error_cnt, n_checks;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  dout_channel u_dout_channel (.MCLK_IN(clk), .RESET_N_IN(rst_n), .MODULATING_IN(mod_pin),
    .ALARM_IN(alarm_pin), .ANALOG_A_IN(ana_a), .ANALOG_B_IN(ana_b), .OUTPUT_MODE_IN(mode),
    .VAR_A_SELECT_IN(sel_a), .VAR_B_SELECT_IN(sel_b), .VAR_C_SELECT_IN(sel_c),
    .TEST_A_OP_IN(op_a), .TEST_B_OP_IN(op_b), .THRESHOLD_A_IN(thr_a),
    .THRESHOLD_B_IN(thr_b), .AB_FUNCTION_IN(fn_ab), .SECOND_FUNCTION_IN(fn_2),
    .POLARITY_IN(pol), .SAW_STEP_IN(step), .OUTPUT_CHANNEL_OUT(dout), .RUN_OK_OUT(run_ok));
  relay_model u_relay_model (.clk_in(clk), .rst_n_in(rst_n), .coil_in(dout), .clear_in(clr),
    .closed_out(closed), .on_cycles_out(on_cyc), .closures_out(closures));
  // ===========================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [3:0] m, input logic [SRC_W-1:0] a, b, c,
      input logic [2:0] oa, ob, input logic [3:0] f1, f2, input logic p);
    mode = m;
    sel_a = a;
    sel_b = b;
    sel_c = c;
    op_a = oa;
    op_b = ob;
    fn_ab = f1;
    fn_2 = f2;
    pol = p;
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ===========================================================
  // Scenarios
  task automatic t_disable;
    cfg(MODE_DISABLE, SRC_ALARM, SRC_ALARM, SRC_DISABLED, 3'h0, 3'h0, FN_OR, FN_OR, 1'b0);
    tick(5);
    chk(dout, 32'h0);
    mode = 4'hA;
    tick(5);
    chk(dout, 32'h0);
    $display("test disable done");
  endtask
  task automatic t_digital;
    cfg(MODE_DIGITAL, SRC_ALARM, SRC_RUN_OK, SRC_DISABLED, 3'h0, 3'h0, FN_OR, FN_OR, 1'b0);
    mod_pin = 1'b1;
    tick(5);
    chk(dout, 32'h1);
    cfg(MODE_DIGITAL, SRC_ALARM, SRC_ANALOG_A, SRC_RUN_OK, 3'h5, 3'h2, FN_NOR, FN_XOR, 1'b0);
    tick(5);
    chk(dout, 32'h1);
    alarm_pin = 1'b1;
    tick(5);
    chk(dout, 32'h0);
    pol = 1'b1;
    tick(5);
    chk(dout, 32'h1);
    alarm_pin = 1'b0;
    $display("test digital done");
  endtask
  task automatic t_run_ok;
    cfg(MODE_DIGITAL, SRC_RUN_OK, SRC_DISABLED, SRC_DISABLED, 3'h0, 3'h0, FN_OR, FN_OR, 1'b1);
    for (int i = 0; i < 2; i++) begin
      mod_pin = i[0];
      tick(5);
      chk(run_ok, i);
      chk(dout, i);
    end
    $display("test run ok done");
  endtask
  task automatic t_latch;
    logic signed [VAR_W-1:0] v[6] = '{16'sh0000, 16'sh0096, 16'sh0032, 16'sh000A,
      -16'sh0096, -16'sh0032};
    logic e[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    cfg(MODE_DBL_ANALOG, SRC_ANALOG_A, SRC_ANALOG_A, SRC_DISABLED, 3'h4, 3'h7,
      FN_SET_RST_RISE, FN_OR, 1'b1);
    thr_a = 16'sh0064;
    thr_b = 16'sh0014;
    for (int i = 0; i < 6; i++) begin
      ana_a = v[i];
      tick(5);
      chk(dout, e[i]);
    end
    rst_n = 1'b0;
    tick(1);
    chk(dout, 32'h0);
    rst_n = 1'b1;
    tick(5);
    chk(dout, 32'h0);
    $display("test latch done");
  endtask
  task automatic t_brake;
    logic [6:0] a = 7'b0111011;
    logic [6:0] lo_b = 7'b0000001;
    logic [6:0] al = 7'b0001000;
    logic [6:0] e = 7'b0110010;
    cfg(MODE_ABSOLUTE_BRAKE_MODE, SRC_ANALOG_A, SRC_ANALOG_B, SRC_DISABLED, 3'h0, 3'h3,
      FN_SET_RST_RISE, FN_OR, 1'b1);
    thr_a = 16'sh0014;
    thr_b = 16'sh0032;
    for (int i = 6; i >= 0; i--) begin
      ana_a = a[i] ? -16'sh001E : 16'sh0000;
      ana_b = lo_b[i] ? 16'sh0028 : 16'sh0064;
      alarm_pin = al[i];
      tick(5);
      chk(dout, e[i]);
    end
    $display("test brake done");
  endtask
  task automatic t_third;
    cfg(MODE_DBL_DIGITAL, SRC_RUN_OK, SRC_RUN_OK, SRC_ALARM, 3'h0, 3'h0, FN_OR, FN_AND, 1'b1);
    mod_pin = 1'b1;
    for (int i = 0; i < 2; i++) begin
      alarm_pin = i[0];
      tick(5);
      chk(dout, i);
    end
    sel_c = SRC_DISABLED;
    alarm_pin = 1'b0;
    tick(5);
    chk(dout, 32'h1);
    $display("test third done");
  endtask
  task automatic t_funcs;
    logic [3:0] fn[4] = '{FN_AND, FN_XOR, FN_NOR, FN_NAND};
    logic [3:0] tt[4] = '{4'h8, 4'h6, 4'h1, 4'h7};
    cfg(MODE_DBL_FULL, SRC_ANALOG_A, SRC_ANALOG_B, SRC_DISABLED, 3'h0, 3'h0, FN_OR, FN_OR, 1'b1);
    thr_a = 16'sh0000;
    thr_b = 16'sh0000;
    for (int f = 0; f < 4; f++) begin
      fn_ab = fn[f];
      for (int k = 0; k < 4; k++) begin
        ana_a = k[0] ? 16'sh0005 : -16'sh0005;
        ana_b = k[1] ? 16'sh0005 : -16'sh0005;
        tick(2);
        chk(dout, tt[f][k]);
      end
    end
    cfg(MODE_ABS_LIFT, SRC_ANALOG_A, SRC_ANALOG_B, SRC_DISABLED, 3'h0, 3'h0, FN_RST_SET_RISE,
      FN_OR, 1'b1);
    {ana_a, ana_b} = '0;
    tick(2);
    chk(dout, 32'h0);
    ana_b = -16'sh0005;
    tick(2);
    chk(dout, 32'h1);
    ana_a = -16'sh0005;
    tick(2);
    chk(dout, 32'h0);
    $display("test functions done");
  endtask
  task automatic t_pwm;
    logic signed [VAR_W-1:0] av[4] = '{16'sh01F4, 16'sh02EE, 16'sh02EE, 16'sh02EE};
    logic signed [VAR_W-1:0] fl[4] = '{16'sh0000, 16'sh0000, 16'sh01F4, 16'sh0000};
    logic [2:0] op[4] = '{3'h0, 3'h0, 3'h0, 3'h2};
    int pct[4] = '{50, 75, 50, 25};
    // One saw period is 100 clocks, so 1000 clocks hold ten periods.
    step = 32'h028F5C29;
    thr_a = 16'sh03E8;
    for (int i = 0; i < 4; i++) begin
      cfg(MODE_PWM, SRC_ANALOG_A, SRC_ANALOG_B, SRC_DISABLED, op[i], 3'h0, FN_OR, FN_OR, 1'b1);
      ana_a = av[i];
      thr_b = fl[i];
      tick(200);
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(1000);
      chk(on_cyc > pct[i] * 10 - 20 && on_cyc < pct[i] * 10 + 20, 32'h1);
      chk(closures > 9 && closures < 11 || closures == 9 || closures == 11, 32'h1);
    end
    $display("test pwm done");
  endtask
  // ===========================================================
  // Main sequence
  initial begin
    {rst_n, mod_pin, alarm_pin, clr, ana_a, ana_b, thr_a, thr_b, step} = '0;
    cfg(MODE_DISABLE, SRC_DISABLED, SRC_DISABLED, SRC_DISABLED, 3'h0, 3'h0, FN_OR, FN_OR, 1'b1);
    tick(3);
    rst_n = 1'b1;
    tick(1);
    chk(dout, 32'h0);
    t_disable;
    t_digital;
    t_run_ok;
    t_latch;
    t_brake;
    t_third;
    t_funcs;
    t_pwm;
    give_verdict;
  end
  initial begin
    #2000000;
    error_cnt++;
    give_verdict;
  end
endmodule
